// ===== rtl/iowc_pkg.sv
package iowc_pkg;
   localparam logic [7:0] IOWC_OPT_ADDR = 8'h00_C8;
   localparam logic [7:0] IOWC_OPT_RESET = 8'h00_00;
   localparam int IOWC_LES_BIT = 6;
   localparam int IOWC_ESB_BIT = 5;
   localparam int IOWC_GEN_BIT = 4;
   localparam logic [7:0] IOWC_OPT_USED = 8'h00_70;
   localparam logic [11:0] IOWC_AXI_OPT = 12'h0_0C8;
   localparam logic [11:0] IOWC_AXI_CTRL = 12'h0_0D0;
   localparam logic [11:0] IOWC_AXI_STAT = 12'h0_0D4;
   localparam logic [11:0] IOWC_AXI_OPTRD = 12'h0_0D8;
   localparam logic [1:0] IOWC_RESP_OKAY = 2'h0;
   localparam logic [1:0] IOWC_RESP_SLVERR = 2'h2;
   localparam int IOWC_STAB_NS = 2000;
   localparam int IOWC_CLK_NS = 25;
   localparam int IOWC_STAB_CYC = (IOWC_STAB_NS + IOWC_CLK_NS - 1) / IOWC_CLK_NS;
   localparam logic [15:0] IOWC_CTRL_RESET = 16'h0_000;

   typedef enum logic [3:0] {
      IOWC_RUN = 4'b0001,
      IOWC_WAIT = 4'b0010,
      IOWC_STOP = 4'b0100,
      IOWC_STAB = 4'b1000
   } iowc_state_type;

   typedef enum logic [2:0] {
      IOWC_MODE_MAIN = 3'b001,
      IOWC_MODE_IRQ = 3'b010,
      IOWC_MODE_NMI = 3'b100
   } iowc_mode_type;

   typedef struct packed {
      logic timer_irq_mask;
      logic reload_timer_overflow_mask;
      logic reload_timer_compare_mask;
      logic converter_irq_mask;
      logic serial_receive_irq_mask;
      logic serial_transmit_irq_mask;
   } iowc_masks_type;

   typedef struct packed {
      logic timer_zero_flag;
      logic reload_timer_overflow_flag;
      logic reload_timer_compare_flag;
      logic converter_done_flag;
      logic serial_byte_received_flag;
      logic serial_byte_sent_flag;
   } iowc_events_type;
endpackage

// ===== rtl/iowc_top.sv
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps
module iowc_top #(
   parameter int STAB_CYCLES = iowc_pkg::IOWC_STAB_CYC
) (
   input wire logic CLK_IN,
   input wire logic RESETN_IN,
   input wire logic S_AXI_AWVALID_IN,
   output logic S_AXI_AWREADY_OUT,
   input wire logic [11:0] S_AXI_AWADDR_IN,
   input wire logic S_AXI_WVALID_IN,
   output logic S_AXI_WREADY_OUT,
   input wire logic [31:0] S_AXI_WDATA_IN,
   input wire logic [3:0] S_AXI_WSTRB_IN,
   output logic S_AXI_BVALID_OUT,
   input wire logic S_AXI_BREADY_IN,
   output logic [1:0] S_AXI_BRESP_OUT,
   input wire logic S_AXI_ARVALID_IN,
   output logic S_AXI_ARREADY_OUT,
   input wire logic [11:0] S_AXI_ARADDR_IN,
   output logic S_AXI_RVALID_OUT,
   input wire logic S_AXI_RREADY_IN,
   output logic [31:0] S_AXI_RDATA_OUT,
   output logic [1:0] S_AXI_RRESP_OUT,
   input wire logic NMI_PIN_IN,
   input wire logic SRC1_PIN_IN,
   input wire logic SRC2_PIN_IN,
   input wire iowc_pkg::iowc_events_type EVENTS_IN,
   input wire logic WATCHDOG_ACTIVE_IN,
   input wire logic CORE_WAIT_IN,
   input wire logic CORE_STOP_IN,
   input wire iowc_pkg::iowc_mode_type CORE_MODE_IN,
   input wire logic [2:0] ACK_IN,
   output logic [4:0] IRQ_REQ_OUT,
   output logic CORE_HALT_OUT,
   output logic OSC_STOP_OUT,
   output logic WAKE_OUT,
   output logic LOWPOWER_SKIP_OUT,
   output logic [1:0] RESUME_OUT
);
   logic [7:0] opt_ff, nxt_opt;
   iowc_pkg::iowc_masks_type masks_ff;
   logic [2:0] nmi_sync_ff, s1_sync_ff, s2_sync_ff;
   logic nmi_lat_ff, s1_lat_ff, s2_lat_ff;
   iowc_pkg::iowc_state_type state_ff, nxt_state;
   iowc_pkg::iowc_mode_type entry_mode_ff;
   logic [15:0] stab_cnt_ff;
   logic [4:0] irq_ff;
   logic halt_ff, osc_ff, wake_ff, skip_ff;
   logic [1:0] resume_ff;
   logic aw_ff, w_ff, bvalid_ff, rvalid_ff;
   logic [11:0] awaddr_ff;
   logic [31:0] wdata_ff, rdata_ff;
   logic [3:0] wstrb_ff;
   logic [1:0] bresp_ff, rresp_ff;

   function automatic logic edge_of(input logic [2:0] sync, input logic rising);
      edge_of = rising ? (sync[1] & ~sync[2]) : (~sync[1] & sync[2]);
   endfunction

   // Option bits
   wire level_edge_select = opt_ff[iowc_pkg::IOWC_LES_BIT];
   wire edge_polarity_select = opt_ff[iowc_pkg::IOWC_ESB_BIT];
   wire gen = opt_ff[iowc_pkg::IOWC_GEN_BIT];

   // Source lines; pins are active low for level and falling modes
   wire nmi_edge = edge_of(nmi_sync_ff, 1'b0);
   wire s1_edge = edge_of(s1_sync_ff, 1'b0);
   wire s2_edge = edge_of(s2_sync_ff, edge_polarity_select);
   wire s1_level = ~s1_sync_ff[1];
   wire s1_req = level_edge_select ? s1_level : s1_lat_ff;
   wire s3_req = (masks_ff.timer_irq_mask & EVENTS_IN.timer_zero_flag)
      | (masks_ff.reload_timer_overflow_mask & EVENTS_IN.reload_timer_overflow_flag)
      | (masks_ff.reload_timer_compare_mask & EVENTS_IN.reload_timer_compare_flag);
   wire s4_req = (masks_ff.converter_irq_mask & EVENTS_IN.converter_done_flag)
      | (masks_ff.serial_receive_irq_mask & EVENTS_IN.serial_byte_received_flag)
      | (masks_ff.serial_transmit_irq_mask & EVENTS_IN.serial_byte_sent_flag);
   wire [3:0] mask_reqs = {s4_req, s3_req, s2_lat_ff, s1_req};
   wire [4:0] nxt_irq = {mask_reqs & {4{gen}}, nmi_lat_ff};
   wire any_pending = |nxt_irq;
   wire ext_pending = nmi_lat_ff | s1_req | s2_lat_ff;
   wire wake_any = gen & any_pending;
   wire wake_ext = gen & ext_pending;
   wire stop_ok = CORE_STOP_IN & ~WATCHDOG_ACTIVE_IN;
   wire enter_req = CORE_WAIT_IN | CORE_STOP_IN;
   wire stab_done = (stab_cnt_ff == 16'(STAB_CYCLES - 1));

   // Low-power sequencing
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         iowc_pkg::IOWC_RUN: begin
            if (enter_req && !any_pending) begin
               nxt_state = stop_ok ? iowc_pkg::IOWC_STOP : iowc_pkg::IOWC_WAIT;
            end
         end
         iowc_pkg::IOWC_WAIT: begin
            if (wake_any) begin
               nxt_state = iowc_pkg::IOWC_RUN;
            end
         end
         iowc_pkg::IOWC_STOP: begin
            if (wake_ext) begin
               nxt_state = iowc_pkg::IOWC_STAB;
            end
         end
         iowc_pkg::IOWC_STAB: begin
            if (stab_done) begin
               nxt_state = iowc_pkg::IOWC_RUN;
            end
         end
         default: nxt_state = iowc_pkg::IOWC_RUN;
      endcase
   end

   wire leaving = (state_ff != iowc_pkg::IOWC_RUN) && (nxt_state == iowc_pkg::IOWC_RUN);
   // Resume code: 0 service wake vector, 1 next instruction, 2 NMI first then next
   wire [1:0] nxt_resume = (entry_mode_ff == iowc_pkg::IOWC_MODE_MAIN) ? 2'h0
      : (entry_mode_ff == iowc_pkg::IOWC_MODE_NMI) ? 2'h1
      : nmi_lat_ff ? 2'h2 : 2'h1;

   // Register bus decode
   wire wr_fire = aw_ff && w_ff && !bvalid_ff;
   wire wr_opt = wr_fire && (awaddr_ff == iowc_pkg::IOWC_AXI_OPT)
      && (wstrb_ff[0] == 1'b1);
   wire wr_ctrl = wr_fire && (awaddr_ff == iowc_pkg::IOWC_AXI_CTRL);
   wire wr_hit = (awaddr_ff == iowc_pkg::IOWC_AXI_OPT) || (awaddr_ff == iowc_pkg::IOWC_AXI_CTRL);
   wire rd_fire = S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
   wire [31:0] stat_word = {20'h0_0000, resume_ff, state_ff, skip_ff, irq_ff[4:0]};
   wire rd_stat = S_AXI_ARADDR_IN == iowc_pkg::IOWC_AXI_STAT;
   wire rd_ctrl = S_AXI_ARADDR_IN == iowc_pkg::IOWC_AXI_CTRL;
   wire rd_hit = rd_stat || rd_ctrl;
   wire [31:0] rd_word = rd_stat ? stat_word : rd_ctrl ? {26'h000_0000, masks_ff} : 32'h0000_0000;
   assign nxt_opt = wdata_ff[7:0] & iowc_pkg::IOWC_OPT_USED;

   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         opt_ff <= iowc_pkg::IOWC_OPT_RESET;
         masks_ff <= '0;
      end else begin
         if (wr_opt) begin
            opt_ff <= nxt_opt;
         end
         if (wr_ctrl && wstrb_ff[0]) begin
            masks_ff <= wdata_ff[5:0];
         end
      end
   end

   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         aw_ff <= 1'b0;
         w_ff <= 1'b0;
         awaddr_ff <= 12'h0_000;
         wdata_ff <= 32'h0000_0000;
         wstrb_ff <= 4'h0;
         bvalid_ff <= 1'b0;
         bresp_ff <= iowc_pkg::IOWC_RESP_OKAY;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= iowc_pkg::IOWC_RESP_OKAY;
      end else begin
         if (S_AXI_AWVALID_IN && !aw_ff) begin
            aw_ff <= 1'b1;
            awaddr_ff <= {S_AXI_AWADDR_IN[11:2], 2'b00};
         end
         if (S_AXI_WVALID_IN && !w_ff) begin
            w_ff <= 1'b1;
            wdata_ff <= S_AXI_WDATA_IN;
            wstrb_ff <= S_AXI_WSTRB_IN;
         end
         if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? iowc_pkg::IOWC_RESP_OKAY : iowc_pkg::IOWC_RESP_SLVERR;
         end else if (bvalid_ff && S_AXI_BREADY_IN) begin
            bvalid_ff <= 1'b0;
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
         end
         if (rd_fire) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_word;
            rresp_ff <= rd_hit ? iowc_pkg::IOWC_RESP_OKAY : iowc_pkg::IOWC_RESP_SLVERR;
         end else if (rvalid_ff && S_AXI_RREADY_IN) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   // Source latches; an edge in the acknowledge cycle wins over the clear
   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         nmi_sync_ff <= 3'h7;
         s1_sync_ff <= 3'h7;
         s2_sync_ff <= 3'h7;
         nmi_lat_ff <= 1'b0;
         s1_lat_ff <= 1'b0;
         s2_lat_ff <= 1'b0;
      end else begin
         nmi_sync_ff <= {nmi_sync_ff[1:0], NMI_PIN_IN};
         s1_sync_ff <= {s1_sync_ff[1:0], SRC1_PIN_IN};
         s2_sync_ff <= {s2_sync_ff[1:0], SRC2_PIN_IN};
         nmi_lat_ff <= nmi_edge | (nmi_lat_ff & ~ACK_IN[0]);
         s1_lat_ff <= (s1_edge & ~level_edge_select) | (s1_lat_ff & ~ACK_IN[1] & ~level_edge_select);
         s2_lat_ff <= s2_edge | (s2_lat_ff & ~ACK_IN[2]);
      end
   end

   always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         state_ff <= iowc_pkg::IOWC_RUN;
         entry_mode_ff <= iowc_pkg::IOWC_MODE_MAIN;
         stab_cnt_ff <= 16'h0_000;
         irq_ff <= 5'h00;
         halt_ff <= 1'b0;
         osc_ff <= 1'b0;
         wake_ff <= 1'b0;
         skip_ff <= 1'b0;
         resume_ff <= 2'h0;
      end else begin
         state_ff <= nxt_state;
         if (state_ff == iowc_pkg::IOWC_RUN && enter_req) begin
            entry_mode_ff <= CORE_MODE_IN;
         end
         stab_cnt_ff <= (state_ff == iowc_pkg::IOWC_STAB) ? stab_cnt_ff + 16'h0_001 : 16'h0_000;
         irq_ff <= nxt_irq;
         halt_ff <= nxt_state != iowc_pkg::IOWC_RUN;
         osc_ff <= nxt_state == iowc_pkg::IOWC_STOP;
         wake_ff <= leaving;
         skip_ff <= (state_ff == iowc_pkg::IOWC_RUN) && enter_req && any_pending;
         if (leaving) begin
            resume_ff <= nxt_resume;
         end
      end
   end

   assign S_AXI_AWREADY_OUT = !aw_ff;
   assign S_AXI_WREADY_OUT = !w_ff;
   assign S_AXI_BVALID_OUT = bvalid_ff;
   assign S_AXI_BRESP_OUT = bresp_ff;
   assign S_AXI_ARREADY_OUT = !rvalid_ff && RESETN_IN;
   assign S_AXI_RVALID_OUT = rvalid_ff;
   assign S_AXI_RDATA_OUT = rdata_ff;
   assign S_AXI_RRESP_OUT = rresp_ff;
   assign IRQ_REQ_OUT = irq_ff;
   assign CORE_HALT_OUT = halt_ff;
   assign OSC_STOP_OUT = osc_ff;
   assign WAKE_OUT = wake_ff;
   assign LOWPOWER_SKIP_OUT = skip_ff;
   assign RESUME_OUT = resume_ff;
endmodule

// ===== dv/iowc_chk.sv
`timescale 1ns/10ps
module iowc_chk #(
   parameter int STAB_CYCLES = 8
) (
   input wire logic CLK_IN,
   input wire logic RESETN_IN,
   input wire logic CORE_WAIT_IN,
   input wire logic CORE_STOP_IN,
   input wire logic WATCHDOG_ACTIVE_IN,
   input wire logic CORE_HALT_OUT,
   input wire logic OSC_STOP_OUT,
   input wire logic WAKE_OUT,
   input wire logic LOWPOWER_SKIP_OUT,
   input wire logic [1:0] RESUME_OUT
);
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (!RESETN_IN);
   halt_cause_a: assert property ($rose(CORE_HALT_OUT) |-> $past(CORE_WAIT_IN | CORE_STOP_IN))
      else $error("halt without instruction");
   skip_nohalt_a: assert property (LOWPOWER_SKIP_OUT |-> !CORE_HALT_OUT ##1 !CORE_HALT_OUT)
      else $error("halt after skip");
   osc_halt_a: assert property (OSC_STOP_OUT |-> CORE_HALT_OUT)
      else $error("oscillator off while running");
   wdog_wait_a: assert property (WATCHDOG_ACTIVE_IN && CORE_STOP_IN && !CORE_HALT_OUT |=>
      !OSC_STOP_OUT)
      else $error("stop honoured with watchdog");
   stop_entry_a: assert property ($rose(OSC_STOP_OUT) |-> $past(CORE_STOP_IN) &&
      !$past(WATCHDOG_ACTIVE_IN))
      else $error("oscillator off without stop");
   wake_end_a: assert property (WAKE_OUT |-> !CORE_HALT_OUT && $past(CORE_HALT_OUT) ##1 !WAKE_OUT)
      else $error("wake pulse misplaced");
   resume_hold_a: assert property (!WAKE_OUT |-> $stable(RESUME_OUT))
      else $error("resume changed without wake");
   stab_hold_a: assert property ($fell(OSC_STOP_OUT) |-> CORE_HALT_OUT [*6])
      else $error("stop exit too early");
endmodule
bind iowc_top iowc_chk #(.STAB_CYCLES(STAB_CYCLES)) u_chk (.CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN),
   .CORE_WAIT_IN(CORE_WAIT_IN), .CORE_STOP_IN(CORE_STOP_IN), .WAKE_OUT(WAKE_OUT),
   .WATCHDOG_ACTIVE_IN(WATCHDOG_ACTIVE_IN), .CORE_HALT_OUT(CORE_HALT_OUT),
   .OSC_STOP_OUT(OSC_STOP_OUT), .LOWPOWER_SKIP_OUT(LOWPOWER_SKIP_OUT), .RESUME_OUT(RESUME_OUT));

// ===== dv/iowc_core_mdl.sv
`timescale 1ns/10ps
module iowc_core_mdl (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic wait_cmd_in,
   input wire logic stop_cmd_in,
   input wire logic ack_en_in,
   input wire logic [2:0] irq_in,
   output logic wait_out,
   output logic stop_out,
   output logic [2:0] ack_out
);
   logic [1:0] cmd_ff;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cmd_ff <= 2'h0;
         ack_out <= 3'h0;
      end else begin
         cmd_ff <= {stop_cmd_in, wait_cmd_in};
         // Routine start clears the latched requests
         ack_out <= ack_en_in ? (irq_in & ~ack_out) : 3'h0;
      end
   end
   assign wait_out = wait_cmd_in & ~cmd_ff[0];
   assign stop_out = stop_cmd_in & ~cmd_ff[1];
endmodule

// ===== dv/iowc_top_tb.sv
`timescale 1ns/10ps
module iowc_top_tb;
   localparam int STB = 8;
   localparam logic [11:0] OPT = iowc_pkg::IOWC_AXI_OPT;
   logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
   logic nmi = 1'b1, s1 = 1'b1, s2 = 1'b1, wdg = 1'b0, wcmd = 1'b0, scmd = 1'b0, acken = 1'b0;
   logic [11:0] aa = 12'h000, ara = 12'h000;
   logic [31:0] wd = 32'h0000_0000, d, rdata;
   iowc_pkg::iowc_events_type ev = '0;
   iowc_pkg::iowc_mode_type mode = iowc_pkg::IOWC_MODE_MAIN;
   logic awr, wr, bv, arr, rv, halt, osc, wake, skip, cw, cs;
   logic [1:0] bresp, rresp, res, r;
   logic [4:0] irq;
   logic [2:0] ack;
   int num_errors = 0, n_compared = 0, cyc = 0, seed, n, i;
   wire logic [8:0] obs = {skip, wake, osc, halt, irq};
   always #12.5 clk = ~clk;
   iowc_top #(.STAB_CYCLES(STB)) dut (.CLK_IN(clk), .RESETN_IN(rst_n),
      .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr), .S_AXI_AWADDR_IN(aa),
      .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wr), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hF),
      .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br), .S_AXI_BRESP_OUT(bresp),
      .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr), .S_AXI_ARADDR_IN(ara),
      .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rr), .S_AXI_RDATA_OUT(rdata),
      .S_AXI_RRESP_OUT(rresp), .NMI_PIN_IN(nmi), .SRC1_PIN_IN(s1), .SRC2_PIN_IN(s2),
      .EVENTS_IN(ev), .WATCHDOG_ACTIVE_IN(wdg), .CORE_WAIT_IN(cw), .CORE_STOP_IN(cs),
      .CORE_MODE_IN(mode), .ACK_IN(ack), .IRQ_REQ_OUT(irq), .CORE_HALT_OUT(halt),
      .OSC_STOP_OUT(osc), .WAKE_OUT(wake), .LOWPOWER_SKIP_OUT(skip), .RESUME_OUT(res));
   iowc_core_mdl u_core (.clk_in(clk), .rst_n_in(rst_n), .wait_cmd_in(wcmd), .stop_cmd_in(scmd),
      .ack_en_in(acken), .irq_in(irq[2:0]), .wait_out(cw), .stop_out(cs), .ack_out(ack));
   task automatic conclude();
      $display("compared %0d errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wfor(input int b, input logic v, output int k);
      k = 0;
      while (obs[b] !== v && k < 200) begin
         @(posedge clk);
         k++;
      end
   endtask
   task automatic axw(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
      @(posedge clk);
      {awv, wv, br} <= 3'h7;
      aa <= a;
      wd <= v;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
      end while (!bv);
      rs = bresp;
      br <= 1'b0;
   endtask
   task automatic axr(input logic [11:0] a, output logic [1:0] rs, output logic [31:0] v);
      @(posedge clk);
      {arv, rr} <= 2'h3;
      ara <= a;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (!rv);
      rs = rresp;
      v = rdata;
      rr <= 1'b0;
   endtask
   task automatic clr();
      acken <= 1'b1;
      repeat (6) @(posedge clk);
      acken <= 1'b0;
   endtask
   task automatic lp(input logic st, input logic wo, input iowc_pkg::iowc_mode_type m,
      input int src, input logic [1:0] er);
      @(posedge clk);
      {wdg, wcmd, scmd} <= {wo, !st, st};
      mode <= m;
      wfor(5, 1'b1, n);
      chk("osc", 32'(st & !wo), 32'(osc));
      {wcmd, scmd} <= 2'h0;
      if (src == 0) nmi <= 1'b0;
      else if (src == 2) s2 <= 1'b1;
      else ev <= 6'h20;
      wfor(7, 1'b1, n);
      chk("resume", 32'(er), 32'(res));
      if (st || src == 3) chk("delay", 32'h1, 32'((st && !wo) ? n >= STB : n < STB));
      {nmi, s2} <= 2'h2;
      ev <= '0;
      clr();
      chk("irq", 32'h0, 32'(irq));
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         conclude();
      end
   end
   initial begin
      seed = $urandom(32'h0000_EE74);
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      chk("irq", 32'h0, 32'(irq));
      axr(OPT, r, d);
      chk("rresp", 32'(iowc_pkg::IOWC_RESP_SLVERR), 32'(r));
      chk("rdata", 32'h0000_0000, d);
      axr(12'h100, r, d);
      chk("unmapped", 32'(iowc_pkg::IOWC_RESP_SLVERR), 32'(r));
      axw(iowc_pkg::IOWC_AXI_CTRL, 32'h0000_003F, r);
      axr(iowc_pkg::IOWC_AXI_CTRL, r, d);
      chk("masks", 32'h0000_003F, d);
      axw(OPT, 32'h0000_008F, r);
      chk("bresp", 32'(iowc_pkg::IOWC_RESP_OKAY), 32'(r));
      for (i = 0; i < 8; i++) begin
         if (i == 4) axw(OPT, 32'h0000_0010, r);
         @(posedge clk);
         d = $urandom_range(63, 1);
         ev <= d[5:0];
         repeat (4) @(posedge clk);
         chk("src34", 32'({|d[2:0], |d[5:3]} & {2{i > 3}}), 32'(irq[4:3]));
      end
      ev <= '0;
      axw(OPT, 32'h0000_0030, r);
      s2 <= 1'b0;
      repeat (8) @(posedge clk);
      chk("src2", 32'h0, 32'(irq[2]));
      s2 <= 1'b1;
      wfor(2, 1'b1, n);
      chk("src2", 32'h1, 32'(irq[2]));
      axw(OPT, 32'h0000_0010, r);
      clr();
      s2 <= 1'b0;
      wfor(2, 1'b1, n);
      chk("src2", 32'h1, 32'(irq[2]));
      clr();
      axw(OPT, 32'h0000_0050, r);
      s1 <= 1'b0;
      wfor(1, 1'b1, n);
      s1 <= 1'b1;
      wfor(1, 1'b0, n);
      chk("src1", 32'h0, 32'(irq[1]));
      axw(OPT, 32'h0000_0010, r);
      s1 <= 1'b0;
      wfor(1, 1'b1, n);
      s1 <= 1'b1;
      repeat (8) @(posedge clk);
      chk("src1", 32'h1, 32'(irq[1]));
      clr();
      nmi <= 1'b0;
      wfor(0, 1'b1, n);
      wcmd <= 1'b1;
      wfor(8, 1'b1, n);
      wcmd <= 1'b0;
      chk("skip", 32'h0, 32'({skip, halt} ^ 2'h2));
      nmi <= 1'b1;
      clr();
      axw(OPT, 32'h0000_0000, r);
      wcmd <= 1'b1;
      wfor(5, 1'b1, n);
      {wcmd, nmi} <= 2'h0;
      ev <= 6'h3F;
      repeat (20) @(posedge clk);
      chk("gen0", 32'h3, 32'({halt, irq[0]}));
      // NMI and source 2 pins back to idle high so reset leaves no false edge behind
      {nmi, s2, rst_n} <= 3'h6;
      ev <= '0;
      @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("reset", 32'h0, 32'({halt, irq}));
      axw(iowc_pkg::IOWC_AXI_CTRL, 32'h0000_003F, r);
      axw(OPT, 32'h0000_0030, r);
      s2 <= 1'b0;
      repeat (8) @(posedge clk);
      lp(1'b0, 1'b0, iowc_pkg::IOWC_MODE_MAIN, 3, 2'h0);
      lp(1'b1, 1'b0, iowc_pkg::IOWC_MODE_NMI, 2, 2'h1);
      lp(1'b0, 1'b0, iowc_pkg::IOWC_MODE_IRQ, 3, 2'h1);
      lp(1'b0, 1'b0, iowc_pkg::IOWC_MODE_IRQ, 0, 2'h2);
      lp(1'b1, 1'b1, iowc_pkg::IOWC_MODE_MAIN, 3, 2'h0);
      conclude();
   end
endmodule
